// ===== swtc_top.sv
// Behaviour
// - Watchdog disabled after always-on power-up
// - Watchdog expires after 2048 reference ticks
// - Early-warning NMI at 1792 ticks
// - Watchdog frozen while debugger halts core
// - 32-bit sleep timer, 1 kHz default
// - Prescaler divides by two to N
// - Compare A, B, wrap as events
// - Sleep timer runs on halt unless configured
// - No RC and no crystal: timer stops
// - WFI without deep select enters idle
// - WFI with deep select starts deep sleep
// - Deep sleep 1 powers core off
// - Deep sleep 2 stops the sleep timer unless the crystal clocks it
// - Deep sleep 0 holds peripherals in reset
// - Pre-deep state waits for system request clear
// - Wake restores power and resets processor
// - Clock gate stops the peripheral clock
// - Pin and debug wakes in deep 1, 2
// - Timer wakes only in deep sleep 0 and 1
// - Core-wake write wakes from deep 0 only
// - Wake recorder latches events continuously
// - Debug request forces deep sleep 0
// - System request blocks deep sleep entry
// - Wake from deep 2 restarts RC oscillator
`default_nettype none
module swtc_top
  import swtc_pkg::*;
#(
  parameter int unsigned GPIO_W = 16
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic CAL_REF_1KHZ,
  input wire logic CRYSTAL_CLOCK_32K,
  input wire logic WFI_EXEC,
  input wire logic DEEP_SLEEP_SELECT,
  input wire logic IRQ_PENDING,
  input wire logic DEBUG_HALT,
  input wire logic DEBUG_POWERUP_REQUEST,
  input wire logic SYSTEM_POWERUP_REQUEST,
  input wire logic [GPIO_W-1:0] GPIO_IN,
  input wire logic SERIAL1_WAKE_PIN,
  input wire logic SELECTABLE_EXTERNAL_IRQ,
  output logic WDOG_NMI,
  output logic WDOG_RESET,
  output logic [2:0] ST_EVENT,
  output logic CPU_IDLE,
  output logic CORE_POWER_EN,
  output logic CPU_RESET,
  output logic PERIPH_RESET,
  output logic LOW_FREQ_RC_OSC_EN,
  output logic SERIAL1_CLK_EN,
  output logic [6:0] PM_STATE
);

  // ============================================================
  // Helpers
  function automatic logic [14:0] presc_limit(input logic [3:0] n);
    logic [3:0] e;
    e = (n < 4'(PRESC_MIN)) ? 4'(PRESC_MIN) : n;
    presc_limit = 15'((32'h1 << e) - 32'h1);
  endfunction : presc_limit

  function automatic logic acc(input logic [7:0] ofs, input logic [7:0] a);
    acc = (a == ofs);
  endfunction : acc

  // ============================================================
  // Registers
  logic [3:0] ctrl_ff;
  logic [3:0] presc_n_ff;
  logic [31:0] cmp_a_ff;
  logic [31:0] cmp_b_ff;
  logic [8:0] wake_en_ff;
  logic [8:0] wake_rec_ff;
  logic [31:0] gate_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic nxt_mapped;
  logic wr_en;
  logic [11:0] wd_cnt_ff;
  logic wd_nmi_ff;
  logic wd_rst_ff;
  logic wd_exp_ff;
  logic [14:0] presc_cnt_ff;
  logic [31:0] st_cnt_ff;
  logic [2:0] st_evt_ff;
  logic ref_prev_ff;
  logic xtal_prev_ff;
  logic [GPIO_W-1:0] gpio_prev_ff;
  logic ser1_prev_ff;
  logic irq_prev_ff;
  logic dbg_prev_ff;
  logic sys_prev_ff;
  swtc_pm_state_t state_ff;
  swtc_pm_state_t nxt_state;
  logic [3:0] rst_cnt_ff;
  logic core_pwr_ff;
  logic cpu_rst_ff;
  logic periph_rst_ff;
  logic rc_en_ff;
  logic idle_ff;
  logic ser1_clk_ff;

  // ============================================================
  // APB slave: one wait state, answer in second access cycle
  assign wr_en = PSEL & PENABLE & pready_ff & PWRITE;

  always_comb begin
    nxt_mapped = 1'b1;
    nxt_prdata = 32'h00000000;
    unique case (PADDR)
      OFS_CTRL: nxt_prdata = {28'h0000000, ctrl_ff};
      OFS_WDOG_RESTART: nxt_prdata = 32'h00000000;
      OFS_PRESCALE: nxt_prdata = {28'h0000000, presc_n_ff};
      OFS_ST_COUNT: nxt_prdata = st_cnt_ff;
      OFS_CMP_A: nxt_prdata = cmp_a_ff;
      OFS_CMP_B: nxt_prdata = cmp_b_ff;
      OFS_WAKE_EN: nxt_prdata = {23'h000000, wake_en_ff};
      OFS_WAKE_REC: nxt_prdata = {23'h000000, wake_rec_ff};
      OFS_WAKE_CORE: nxt_prdata = 32'h00000000;
      OFS_CLK_GATE: nxt_prdata = gate_ff;
      OFS_STATUS: nxt_prdata = {20'h00000, 2'h0, wd_exp_ff, wd_nmi_ff,
                                1'b0, state_ff};
      default: nxt_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= PSEL & PENABLE & ~pready_ff;
      pslverr_ff <= PSEL & PENABLE & ~pready_ff & ~nxt_mapped;
      if (PSEL & PENABLE & ~pready_ff & ~PWRITE) begin
        prdata_ff <= nxt_prdata;
      end else begin
        prdata_ff <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_ff <= CTRL_RESET;
      presc_n_ff <= PRESCALE_RESET;
      cmp_a_ff <= CMP_RESET;
      cmp_b_ff <= CMP_RESET;
      wake_en_ff <= WAKE_EN_RESET;
      gate_ff <= GATE_RESET;
    end else if (wr_en) begin
      if (acc(OFS_CTRL, PADDR)) begin
        ctrl_ff <= PWDATA[3:0];
      end
      if (acc(OFS_PRESCALE, PADDR)) begin
        presc_n_ff <= PWDATA[3:0];
      end
      if (acc(OFS_CMP_A, PADDR)) begin
        cmp_a_ff <= PWDATA;
      end
      if (acc(OFS_CMP_B, PADDR)) begin
        cmp_b_ff <= PWDATA;
      end
      if (acc(OFS_WAKE_EN, PADDR)) begin
        wake_en_ff <= PWDATA[8:0];
      end
      if (acc(OFS_CLK_GATE, PADDR)) begin
        // Only the serial-1 gate exists; the reserved bit is kept as written
        gate_ff <= {26'h0000000, PWDATA[5], 3'h0, PWDATA[GATE_SER1_BIT], 1'b0};
      end
    end
  end

  // ============================================================
  // Reference edges and pin history (inputs are synchronous)
  logic ref_tick;
  logic xtal_tick;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ref_prev_ff <= 1'b0;
      xtal_prev_ff <= 1'b0;
    end else begin
      ref_prev_ff <= CAL_REF_1KHZ;
      xtal_prev_ff <= CRYSTAL_CLOCK_32K;
    end
  end
  // The 1 kHz reference is derived from the RC oscillator, so it dies
  // with the oscillator in deep sleep 2.
  assign ref_tick = CAL_REF_1KHZ & ~ref_prev_ff & rc_en_ff;
  assign xtal_tick = CRYSTAL_CLOCK_32K & ~xtal_prev_ff;

  // ============================================================
  // Watchdog
  logic wd_tick;
  logic wd_restart;
  assign wd_restart = wr_en & acc(OFS_WDOG_RESTART, PADDR);
  assign wd_tick = ref_tick & ctrl_ff[CTRL_WDOG_EN_BIT] & ~DEBUG_HALT;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wd_cnt_ff <= 12'h000;
      wd_nmi_ff <= 1'b0;
      wd_rst_ff <= 1'b0;
      wd_exp_ff <= 1'b0;
    end else begin
      wd_rst_ff <= 1'b0;
      if (wd_restart | ~ctrl_ff[CTRL_WDOG_EN_BIT]) begin
        wd_cnt_ff <= 12'h000;
        wd_nmi_ff <= 1'b0;
      end else if (wd_tick) begin
        if (wd_cnt_ff == 12'(WDOG_TIMEOUT_TICKS - 1)) begin
          wd_cnt_ff <= 12'h000;
          wd_rst_ff <= 1'b1;
          wd_exp_ff <= 1'b1;
          wd_nmi_ff <= 1'b0;
        end else begin
          wd_cnt_ff <= wd_cnt_ff + 12'h001;
          if (wd_cnt_ff == 12'(WDOG_WARN_TICKS - 1)) begin
            wd_nmi_ff <= 1'b1;
          end
        end
      end
    end
  end

  // ============================================================
  // Sleep timer
  logic st_src_tick;
  logic st_tick;
  logic [31:0] st_next;
  logic st_run;
  assign st_src_tick = ctrl_ff[CTRL_CLK_SEL_BIT] ? xtal_tick : ref_tick;
  // Deep sleep 2 stops the timer unless the crystal keeps it alive
  assign st_run = ~(ctrl_ff[CTRL_PAUSE_BIT] & DEBUG_HALT) &
                  ~((state_ff == PM_DEEP2) &
                    ~ctrl_ff[CTRL_CLK_SEL_BIT]);
  assign st_tick = st_src_tick & st_run &
                   (presc_cnt_ff == presc_limit(presc_n_ff));
  assign st_next = st_cnt_ff + 32'h00000001;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      presc_cnt_ff <= 15'h0000;
      st_cnt_ff <= 32'h00000000;
      st_evt_ff <= 3'h0;
    end else begin
      if (st_src_tick & st_run) begin
        if (presc_cnt_ff >= presc_limit(presc_n_ff)) begin
          presc_cnt_ff <= 15'h0000;
        end else begin
          presc_cnt_ff <= presc_cnt_ff + 15'h0001;
        end
      end
      if (st_tick) begin
        st_cnt_ff <= st_next;
      end
      st_evt_ff[0] <= st_tick & (st_next == cmp_a_ff);
      st_evt_ff[1] <= st_tick & (st_next == cmp_b_ff);
      st_evt_ff[2] <= st_tick & (st_cnt_ff == 32'hffffffff);
    end
  end

  // ============================================================
  // Wake detection and recording
  swtc_wake_t wake_ev;
  logic [8:0] wake_clr;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      gpio_prev_ff <= '0;
      ser1_prev_ff <= 1'b0;
      irq_prev_ff <= 1'b0;
      dbg_prev_ff <= 1'b0;
      sys_prev_ff <= 1'b0;
    end else begin
      gpio_prev_ff <= GPIO_IN;
      ser1_prev_ff <= SERIAL1_WAKE_PIN;
      irq_prev_ff <= SELECTABLE_EXTERNAL_IRQ;
      dbg_prev_ff <= DEBUG_POWERUP_REQUEST;
      sys_prev_ff <= SYSTEM_POWERUP_REQUEST;
    end
  end

  always_comb begin
    wake_ev.gpio = |(GPIO_IN ^ gpio_prev_ff);
    wake_ev.ser1 = SERIAL1_WAKE_PIN ^ ser1_prev_ff;
    wake_ev.ext_irq = SELECTABLE_EXTERNAL_IRQ ^ irq_prev_ff;
    wake_ev.dbg_pwrup = DEBUG_POWERUP_REQUEST & ~dbg_prev_ff;
    wake_ev.sys_pwrup = SYSTEM_POWERUP_REQUEST & ~sys_prev_ff;
    wake_ev.st_cmp_a = st_evt_ff[0];
    wake_ev.st_cmp_b = st_evt_ff[1];
    wake_ev.st_wrap = st_evt_ff[2];
    wake_ev.wake_core = wr_en & acc(OFS_WAKE_CORE, PADDR) & PWDATA[0];
  end

  assign wake_clr = (wr_en & acc(OFS_WAKE_REC, PADDR)) ? PWDATA[8:0] : 9'h000;

  // Write-one-to-clear; a new event in the clearing cycle wins
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wake_rec_ff <= 9'h000;
    end else begin
      wake_rec_ff <= (wake_rec_ff & ~wake_clr) | wake_ev;
    end
  end

  // ============================================================
  // Power-management state machine
  logic [8:0] wake_hit;
  assign wake_hit = wake_ev & wake_en_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PM_RUN: begin
        if (WFI_EXEC & ~DEEP_SLEEP_SELECT) begin
          nxt_state = PM_IDLE;
        end else if (WFI_EXEC & DEEP_SLEEP_SELECT) begin
          nxt_state = PM_PRE_DEEP;
        end
      end
      PM_IDLE: begin
        if (IRQ_PENDING) begin
          nxt_state = PM_RUN;
        end
      end
      PM_PRE_DEEP: begin
        if (~SYSTEM_POWERUP_REQUEST) begin
          if (DEBUG_POWERUP_REQUEST) begin
            nxt_state = PM_DEEP0;
          end else if (ctrl_ff[CTRL_RC_OFF_BIT]) begin
            nxt_state = PM_DEEP2;
          end else begin
            nxt_state = PM_DEEP1;
          end
        end
      end
      PM_DEEP0: begin
        if (|(wake_hit & WAKE_MASK_DS0)) begin
          nxt_state = PM_WAKE_RST;
        end
      end
      PM_DEEP1: begin
        if (|(wake_hit & WAKE_MASK_DS1)) begin
          nxt_state = PM_WAKE_RST;
        end
      end
      PM_DEEP2: begin
        if (|(wake_hit & WAKE_MASK_DS2)) begin
          nxt_state = PM_WAKE_RST;
        end
      end
      PM_WAKE_RST: begin
        if (rst_cnt_ff == 4'(CORE_RST_CYCLES - 1)) begin
          nxt_state = PM_RUN;
        end
      end
      default: nxt_state = PM_RUN;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= PM_RUN;
      rst_cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == PM_WAKE_RST) begin
        rst_cnt_ff <= rst_cnt_ff + 4'h1;
      end else begin
        rst_cnt_ff <= 4'h0;
      end
    end
  end

  // Outputs follow the next state so they change with the state itself
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      core_pwr_ff <= 1'b1;
      cpu_rst_ff <= 1'b0;
      periph_rst_ff <= 1'b0;
      rc_en_ff <= 1'b1;
      idle_ff <= 1'b0;
    end else begin
      core_pwr_ff <= ~((nxt_state == PM_DEEP1) |
                       (nxt_state == PM_DEEP2));
      cpu_rst_ff <= (nxt_state == PM_WAKE_RST);
      periph_rst_ff <= (nxt_state == PM_DEEP0);
      rc_en_ff <= (nxt_state != PM_DEEP2);
      idle_ff <= (nxt_state == PM_IDLE);
    end
  end

  // ============================================================
  // Peripheral clock gating; a stopped clock freezes the peripheral's
  // registers, which is why gating a busy peripheral is unsafe.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ser1_clk_ff <= 1'b1;
    end else begin
      ser1_clk_ff <= ~gate_ff[GATE_SER1_BIT];
    end
  end

  // ============================================================
  // Outputs
  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign WDOG_NMI = wd_nmi_ff;
  assign WDOG_RESET = wd_rst_ff;
  assign ST_EVENT = st_evt_ff;
  assign CPU_IDLE = idle_ff;
  assign CORE_POWER_EN = core_pwr_ff;
  assign CPU_RESET = cpu_rst_ff;
  assign PERIPH_RESET = periph_rst_ff;
  assign LOW_FREQ_RC_OSC_EN = rc_en_ff;
  assign SERIAL1_CLK_EN = ser1_clk_ff;
  assign PM_STATE = state_ff;

endmodule : swtc_top
`default_nettype wire

// ===== swtc_pkg.sv
`default_nettype none
package swtc_pkg;
  // ============================================================
  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REF_HZ = 1000;
  localparam int unsigned WDOG_TIMEOUT_MS = 2048;
  localparam int unsigned WDOG_WARN_MS = 1792;
  localparam int unsigned WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_MS * REF_HZ / 1000;
  localparam int unsigned WDOG_WARN_TICKS = WDOG_WARN_MS * REF_HZ / 1000;
  localparam int unsigned CORE_RST_TIME_NS = 40;
  localparam int unsigned CORE_RST_CYCLES =
    (CORE_RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PRESC_MIN = 1;
  localparam int unsigned PRESC_MAX = 15;

  // ============================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDOG_RESTART = 8'h04;
  localparam logic [7:0] OFS_PRESCALE = 8'h08;
  localparam logic [7:0] OFS_ST_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CMP_A = 8'h10;
  localparam logic [7:0] OFS_CMP_B = 8'h14;
  localparam logic [7:0] OFS_WAKE_EN = 8'h18;
  localparam logic [7:0] OFS_WAKE_REC = 8'h1c;
  localparam logic [7:0] OFS_WAKE_CORE = 8'h20;
  localparam logic [7:0] OFS_CLK_GATE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // ============================================================
  // Fields and reset values
  localparam int unsigned CTRL_WDOG_EN_BIT = 0;
  localparam int unsigned CTRL_CLK_SEL_BIT = 1;
  localparam int unsigned CTRL_PAUSE_BIT = 2;
  localparam int unsigned CTRL_RC_OFF_BIT = 3;
  localparam int unsigned GATE_SER1_BIT = 1;
  localparam int unsigned STAT_NMI_BIT = 8;
  localparam int unsigned STAT_EXP_BIT = 9;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] PRESCALE_RESET = 4'h1;
  localparam logic [31:0] CMP_RESET = 32'hffffffff;
  localparam logic [8:0] WAKE_EN_RESET = 9'h1ff;
  localparam logic [31:0] GATE_RESET = 32'h00000000;

  // ============================================================
  // Wake sources
  typedef struct packed {
    logic wake_core;
    logic st_wrap;
    logic st_cmp_b;
    logic st_cmp_a;
    logic sys_pwrup;
    logic dbg_pwrup;
    logic ext_irq;
    logic ser1;
    logic gpio;
  } swtc_wake_t;

  localparam logic [8:0] WAKE_MASK_DS0 = 9'h1ff;
  localparam logic [8:0] WAKE_MASK_DS1 = 9'h0ff;
  localparam logic [8:0] WAKE_MASK_DS2 = 9'h01f;

  typedef enum logic [6:0] {
    PM_RUN = 7'h01,
    PM_IDLE = 7'h02,
    PM_PRE_DEEP = 7'h04,
    PM_DEEP0 = 7'h08,
    PM_DEEP1 = 7'h10,
    PM_DEEP2 = 7'h20,
    PM_WAKE_RST = 7'h40
  } swtc_pm_state_t;
endpackage : swtc_pkg
`default_nettype wire

// ===== swtc_checker.sv
`default_nettype none
module swtc_checker
  import swtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic WFI_EXEC,
  input wire logic DEEP_SLEEP_SELECT,
  input wire logic IRQ_PENDING,
  input wire logic DEBUG_POWERUP_REQUEST,
  input wire logic SYSTEM_POWERUP_REQUEST,
  input wire logic WDOG_NMI,
  input wire logic WDOG_RESET,
  input wire logic CPU_IDLE,
  input wire logic CORE_POWER_EN,
  input wire logic CPU_RESET,
  input wire logic PERIPH_RESET,
  input wire logic LOW_FREQ_RC_OSC_EN,
  input wire logic SERIAL1_CLK_EN,
  input wire logic [6:0] PM_STATE
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // ==========
  // Sleep sequencing
  sequence wfi_s(logic dp);
    PM_STATE == PM_RUN && WFI_EXEC && DEEP_SLEEP_SELECT == dp;
  endsequence
  sequence rst_hold_s;
    CPU_RESET [*8] ##1 CPU_RESET [*2];
  endsequence
  idle_entry_a: assert property (wfi_s(1'b0) |=>
    PM_STATE == PM_IDLE && CPU_IDLE && CORE_POWER_EN)
    else $error("idle entry wrong");
  idle_exit_a: assert property (PM_STATE == PM_IDLE && IRQ_PENDING
    |-> ##[1:2] PM_STATE == PM_RUN && !CPU_IDLE)
    else $error("idle exit missing");
  deep_entry_a: assert property (wfi_s(1'b1) |=>
    PM_STATE == PM_PRE_DEEP && CORE_POWER_EN)
    else $error("pre-deep entry wrong");
  pre_deep_hold_a: assert property (PM_STATE == PM_PRE_DEEP &&
    SYSTEM_POWERUP_REQUEST |=> PM_STATE == PM_PRE_DEEP && !PERIPH_RESET)
    else $error("pre-deep left early");
  debug_deep0_a: assert property (PM_STATE == PM_PRE_DEEP &&
    !SYSTEM_POWERUP_REQUEST && DEBUG_POWERUP_REQUEST |=>
    PM_STATE == PM_DEEP0 && PERIPH_RESET && CORE_POWER_EN)
    else $error("debug deep sleep wrong");
  deep1_power_a: assert property (PM_STATE == PM_DEEP1 |->
    !CORE_POWER_EN && LOW_FREQ_RC_OSC_EN)
    else $error("deep 1 power wrong");
  deep2_power_a: assert property (PM_STATE == PM_DEEP2 |->
    !CORE_POWER_EN && !LOW_FREQ_RC_OSC_EN)
    else $error("deep 2 power wrong");
  wake_restore_a: assert property (PM_STATE == PM_WAKE_RST |->
    CORE_POWER_EN && LOW_FREQ_RC_OSC_EN && CPU_RESET)
    else $error("wake restore wrong");
  wake_reset_a: assert property ($rose(CPU_RESET) |-> rst_hold_s
    ##1 !CPU_RESET && PM_STATE == PM_RUN)
    else $error("core reset length wrong");
  expiry_warn_a: assert property (WDOG_RESET |-> $past(WDOG_NMI)
    ##1 !WDOG_RESET)
    else $error("expiry without warning");
  gate_write_a: assert property (PSEL && PENABLE && PREADY && PWRITE
    && PADDR == OFS_CLK_GATE |-> ##2
    SERIAL1_CLK_EN != $past(PWDATA[GATE_SER1_BIT], 2))
    else $error("clock gate wrong");
  ready_pulse_a: assert property (PREADY |=> !PREADY && !PSLVERR)
    else $error("ready held too long");
endmodule : swtc_checker

bind swtc_top swtc_checker swtc_checker_inst (.CLOCK(CLOCK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .WFI_EXEC(WFI_EXEC), .DEEP_SLEEP_SELECT(DEEP_SLEEP_SELECT),
  .IRQ_PENDING(IRQ_PENDING), .DEBUG_POWERUP_REQUEST(DEBUG_POWERUP_REQUEST),
  .SYSTEM_POWERUP_REQUEST(SYSTEM_POWERUP_REQUEST), .WDOG_NMI(WDOG_NMI),
  .WDOG_RESET(WDOG_RESET), .CPU_IDLE(CPU_IDLE),
  .CORE_POWER_EN(CORE_POWER_EN), .CPU_RESET(CPU_RESET),
  .PERIPH_RESET(PERIPH_RESET), .LOW_FREQ_RC_OSC_EN(LOW_FREQ_RC_OSC_EN),
  .SERIAL1_CLK_EN(SERIAL1_CLK_EN), .PM_STATE(PM_STATE));
`default_nettype wire

// ===== swtc_core_model.sv
`default_nettype none
module swtc_core_model (
  input wire logic clock,
  input wire logic cpu_reset,
  output logic wfi_exec,
  output logic deep_sel,
  output logic dbg_req,
  output logic sys_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wfi_exec = 1'b0;
    deep_sel = 1'b0;
    dbg_req = 1'b0;
    sys_req = 1'b0;
  end
  // ==========
  // Core and debug port actions
  // A core held in reset executes nothing, so no sleep request then
  task automatic wfi(input logic deep);
    @(posedge clock);
    while (cpu_reset !== 1'b0) @(posedge clock);
    deep_sel <= deep;
    wfi_exec <= 1'b1;
    @(posedge clock);
    wfi_exec <= 1'b0;
  endtask : wfi
  task automatic reqs(input logic dbg, input logic sys);
    @(posedge clock);
    dbg_req <= dbg;
    sys_req <= sys;
  endtask : reqs
endmodule : swtc_core_model
`default_nettype wire

// ===== sleep_wake_timer_control_bench.sv
`default_nettype none
module sleep_wake_timer_control_bench;
  import swtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ref_clk = 1'b0;
  logic xtal_clk = 1'b0;
  logic [15:0] gpio = 16'h0;
  logic ser1_pin = 1'b0;
  logic ext_irq = 1'b0;
  logic irq = 1'b0;
  logic halt = 1'b0;
  logic pready, pslverr, wfi, deep_sel, dbg_req, sys_req;
  logic nmi, wrst, idle, core_pwr, cpu_rst, per_rst, rc_en, ser1_clk, err;
  logic [31:0] prdata, rd, c0;
  logic [2:0] st_event;
  logic [6:0] pm_state;
  int n_errors = 0;
  int num_checks = 0;
  int evt [4] = '{default: 0};

  swtc_top swtc_top_inst (.CLOCK(clock), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .CAL_REF_1KHZ(ref_clk), .CRYSTAL_CLOCK_32K(xtal_clk), .WFI_EXEC(wfi),
    .DEEP_SLEEP_SELECT(deep_sel), .IRQ_PENDING(irq), .DEBUG_HALT(halt),
    .DEBUG_POWERUP_REQUEST(dbg_req), .SYSTEM_POWERUP_REQUEST(sys_req),
    .GPIO_IN(gpio), .SERIAL1_WAKE_PIN(ser1_pin),
    .SELECTABLE_EXTERNAL_IRQ(ext_irq), .WDOG_NMI(nmi), .WDOG_RESET(wrst),
    .ST_EVENT(st_event), .CPU_IDLE(idle), .CORE_POWER_EN(core_pwr),
    .CPU_RESET(cpu_rst), .PERIPH_RESET(per_rst),
    .LOW_FREQ_RC_OSC_EN(rc_en), .SERIAL1_CLK_EN(ser1_clk),
    .PM_STATE(pm_state));
  swtc_core_model swtc_core_model_inst (.clock(clock), .cpu_reset(cpu_rst),
    .wfi_exec(wfi), .deep_sel(deep_sel), .dbg_req(dbg_req),
    .sys_req(sys_req));

  always #2 clock = ~clock;
  // One-cycle pulses are counted so that later checks can see them
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) if (st_event[i] === 1'b1) evt[i]++;
    if (wrst === 1'b1) evt[3]++;
  end

  // ==========
  // Bus, stimulus and compare helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("ERROR %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    #1;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  task automatic cnt;
    apb(1'b0, OFS_ST_COUNT, 32'h0);
    c0 = rd;
  endtask : cnt
  // Eight cycles a tick keeps edges well apart for the edge detectors
  task automatic tick(input bit xtal, input int n);
    repeat (n) begin
      @(posedge clock);
      if (xtal) xtal_clk <= 1'b1;
      else ref_clk <= 1'b1;
      repeat (4) @(posedge clock);
      xtal_clk <= 1'b0;
      ref_clk <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (6) @(posedge clock);
    #1;
  endtask : tick
  task automatic wait_state(input logic [6:0] s);
    int n;
    n = 0;
    while (pm_state !== s && n < 64) begin
      @(posedge clock);
      n++;
    end
    #1;
    check(pm_state, s);
  endtask : wait_state
  task automatic deep(input logic [6:0] s);
    apb(1'b1, OFS_WAKE_REC, 32'h1ff);
    swtc_core_model_inst.wfi(1'b1);
    wait_state(s);
  endtask : deep

  // ==========
  // Scenarios
  task automatic t_regs;
    rdc(OFS_CTRL, {28'h0, CTRL_RESET});
    rdc(OFS_PRESCALE, {28'h0, PRESCALE_RESET});
    rdc(OFS_CMP_B, CMP_RESET);
    rdc(OFS_WAKE_EN, {23'h0, WAKE_EN_RESET});
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_wdog;
    tick(0, 1800);
    check(nmi, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1);
    tick(0, 1000);
    @(posedge clock) halt <= 1'b1;
    tick(0, 600);
    @(posedge clock) halt <= 1'b0;
    tick(0, 791);
    check(nmi, 1'b0);
    tick(0, 1);
    check(nmi, 1'b1);
    apb(1'b1, OFS_WDOG_RESTART, 32'h0);
    check(nmi, 1'b0);
    tick(0, 2047);
    check(evt[3], 32'h0);
    tick(0, 1);
    check(evt[3], 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd[STAT_EXP_BIT], 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_wdog
  task automatic t_timer;
    cnt();
    tick(0, 8);
    rdc(OFS_ST_COUNT, c0 + 32'h4);
    apb(1'b1, OFS_PRESCALE, 32'h2);
    cnt();
    apb(1'b1, OFS_CMP_A, c0 + 32'h1);
    apb(1'b1, OFS_CMP_B, c0 + 32'h2);
    tick(0, 8);
    rdc(OFS_ST_COUNT, c0 + 32'h2);
    check(evt[0] + evt[1], 32'h2);
    apb(1'b1, OFS_CTRL, 32'h2);
    cnt();
    tick(0, 8);
    tick(1, 8);
    rdc(OFS_ST_COUNT, c0 + 32'h2);
    @(posedge clock) halt <= 1'b1;
    tick(1, 4);
    rdc(OFS_ST_COUNT, c0 + 32'h3);
    apb(1'b1, OFS_CTRL, 32'h6);
    tick(1, 4);
    rdc(OFS_ST_COUNT, c0 + 32'h3);
    @(posedge clock) halt <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_timer
  task automatic t_sleep;
    swtc_core_model_inst.wfi(1'b0);
    wait_state(PM_IDLE);
    check(idle & core_pwr, 1'b1);
    @(posedge clock) irq <= 1'b1;
    wait_state(PM_RUN);
    @(posedge clock) irq <= 1'b0;
    swtc_core_model_inst.reqs(1'b0, 1'b1);
    deep(PM_PRE_DEEP);
    repeat (20) @(posedge clock);
    wait_state(PM_PRE_DEEP);
    swtc_core_model_inst.reqs(1'b0, 1'b0);
    wait_state(PM_DEEP1);
    @(posedge clock) gpio <= 16'h0010;
    wait_state(PM_WAKE_RST);
    wait_state(PM_RUN);
    rdc(OFS_WAKE_REC, 32'h1);
    swtc_core_model_inst.reqs(1'b1, 1'b0);
    deep(PM_DEEP0);
    check(per_rst & core_pwr, 1'b1);
    apb(1'b1, OFS_WAKE_CORE, 32'h1);
    wait_state(PM_WAKE_RST);
    wait_state(PM_RUN);
    swtc_core_model_inst.reqs(1'b0, 1'b0);
    cnt();
    apb(1'b1, OFS_CMP_A, c0 + 32'h1);
    deep(PM_DEEP1);
    apb(1'b1, OFS_WAKE_CORE, 32'h1);
    wait_state(PM_DEEP1);
    tick(0, 4);
    wait_state(PM_RUN);
    apb(1'b1, OFS_CTRL, 32'h8);
    cnt();
    apb(1'b1, OFS_CMP_A, c0 + 32'h1);
    deep(PM_DEEP2);
    tick(0, 8);
    wait_state(PM_DEEP2);
    check(rc_en, 1'b0);
    @(posedge clock) ser1_pin <= 1'b1;
    wait_state(PM_WAKE_RST);
    wait_state(PM_RUN);
    check(rc_en, 1'b1);
    rdc(OFS_ST_COUNT, c0);
    deep(PM_DEEP2);
    @(posedge clock) ext_irq <= 1'b1;
    wait_state(PM_RUN);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_sleep
  task automatic t_gate;
    apb(1'b1, OFS_CLK_GATE, 32'h22);
    check(ser1_clk, 1'b0);
    rdc(OFS_CLK_GATE, 32'h22);
    apb(1'b1, OFS_CLK_GATE, 32'h0);
    check(ser1_clk, 1'b1);
  endtask : t_gate

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_wdog();
    t_timer();
    t_sleep();
    t_gate();
    complete_run();
  end
  initial begin
    #400000;
    n_errors++;
    $display("ERROR %0t: run did not finish", $time);
    complete_run();
  end
endmodule : sleep_wake_timer_control_bench
`default_nettype wire
